// ==== src/vpa_pkg.sv ====
// Contract
// - Graphics registers: write index, then access data
// - Graphics index four bits, upper bits zero
// - Sequencer registers: three-bit index, then data port
// - Plane write mask gates writes in all modes
// - Secondary font from bits 3:2 and 5
// - Primary font from bits 1:0 and 4
// - Differing fonts: attribute bit 3 picks font
// - Font select needs extended memory, else maps 0,4
// - Chain-4: address bits 1:0 pick plane
// - Odd/even steers writes only, else mask chooses
// - Extended memory clear limits access to 64 KB
// - Index 7 write holds hcount until index 0-6
// - Line counter advances only from display enable
// - Write mode 0: enabled planes take fill bit
// - Unfilled planes take processor data; mode 0 only
// - Write mode 3: rotated data and bit mask
// - Read mode 1: compare included planes per bit
// - Reserved bits ignore writes, read zero
package vpa_pkg;

    // Port addresses in I/O or memory offset space
    localparam logic [15:0] VPA_SEQ_INDEX_PORT = 16'h03c4;
    localparam logic [15:0] VPA_SEQ_DATA_PORT  = 16'h03c5;
    localparam logic [15:0] VPA_GFX_INDEX_PORT = 16'h03ce;
    localparam logic [15:0] VPA_GFX_DATA_PORT  = 16'h03cf;

    // Index widths
    localparam int VPA_SEQ_IDX_W = 3;
    localparam int VPA_GFX_IDX_W = 4;

    // Sequencer indices
    localparam logic [2:0] VPA_SEQ_PLANE_MASK = 3'h2;
    localparam logic [2:0] VPA_SEQ_FONT_SEL   = 3'h3;
    localparam logic [2:0] VPA_SEQ_MEM_MODE   = 3'h4;
    localparam logic [2:0] VPA_SEQ_HC_HOLD    = 3'h7;

    // Graphics indices
    localparam logic [3:0] VPA_GFX_FILL_VAL  = 4'h0;
    localparam logic [3:0] VPA_GFX_FILL_EN   = 4'h1;
    localparam logic [3:0] VPA_GFX_MATCH_COL = 4'h2;

    // Field layout of font_bank_select
    localparam int VPA_FONT_A_LO = 0;
    localparam int VPA_FONT_A_HI = 4;
    localparam int VPA_FONT_B_LO = 2;
    localparam int VPA_FONT_B_HI = 5;
    localparam int VPA_FONT_W    = 6;

    // Field layout of memory_map_mode
    localparam int VPA_MM_EXT    = 1;
    localparam int VPA_MM_SEQ    = 2;
    localparam int VPA_MM_CHAIN4 = 3;
    localparam logic [7:0] VPA_MM_DEFINED = 8'h0e;

    // Reset values
    localparam logic [7:0] VPA_RST_BYTE  = 8'h00;
    localparam logic [3:0] VPA_RST_PLANE = 4'h0;

    // Planar memory geometry: 8 KB font banks in 64 KB planes
    localparam int VPA_PLANES     = 4;
    localparam int VPA_PLANE_AW   = 16;
    localparam int VPA_CPU_AW     = 18;
    localparam int VPA_BANK_SHIFT = 13;

    // Write modes of the neighbouring mode register
    localparam logic [1:0] VPA_WMODE_0 = 2'h0;
    localparam logic [1:0] VPA_WMODE_3 = 2'h3;

    typedef logic [VPA_PLANES-1:0][7:0] vpa_plane_bytes_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vpa_io_req_s;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [VPA_CPU_AW-1:0] addr;
    } vpa_mem_req_s;

    typedef struct packed {
        logic                    we_any;
        logic                    re;
        logic [VPA_PLANES-1:0]   we;
        logic [VPA_PLANE_AW-1:0] addr;
        vpa_plane_bytes_t        data;
        logic [7:0]              bitmask;
    } vpa_plane_req_s;

endpackage : vpa_pkg

// ==== src/vpa_plane_steer.sv ====
`timescale 1ns/1ps
module vpa_plane_steer
    import vpa_pkg::*;
(
    // Mode bits
    input  wire logic                    chain4,
    input  wire logic                    seq_addr,
    input  wire logic                    ext_mem,
    // Access
    input  wire logic [VPA_CPU_AW-1:0]   cpu_addr,
    input  wire logic                    is_write,
    input  wire logic [VPA_PLANES-1:0]   write_mask,
    input  wire logic [1:0]              read_plane_sel,
    // Result
    output logic      [VPA_PLANES-1:0]   plane_en,
    output logic      [1:0]              read_plane,
    output logic      [VPA_PLANE_AW-1:0] plane_off,
    output logic                         in_range
);

    logic [VPA_PLANES-1:0] chain_sel;
    logic [VPA_PLANES-1:0] odd_even_sel;
    logic                  odd_even_wr;

    // Without extended memory only the first 64 KB answers
    assign in_range = ext_mem | (cpu_addr[VPA_CPU_AW-1:VPA_PLANE_AW] == 2'h0);

    // Chain-4 decodes the plane from the two low address bits
    assign chain_sel    = 4'h1 << cpu_addr[1:0];
    assign odd_even_sel = cpu_addr[0] ? 4'ha : 4'h5;
    assign odd_even_wr  = !chain4 && !seq_addr && is_write;

    // The write mask still gates every mode
    assign plane_en = chain4 ? (chain_sel & write_mask) :
                      odd_even_wr ? (odd_even_sel & write_mask) : write_mask;

    // Reads ignore odd/even; chain-4 overrides the read plane select
    assign read_plane = chain4 ? cpu_addr[1:0] : read_plane_sel;

    // Offset within each plane; chain-4 and odd/even fold address bits away
    assign plane_off = chain4 ? cpu_addr[VPA_CPU_AW-1:2] :
                       odd_even_wr ? cpu_addr[VPA_PLANE_AW:1] :
                       cpu_addr[VPA_PLANE_AW-1:0];

endmodule : vpa_plane_steer

// ==== src/vpa_plane_access.sv ====
`timescale 1ns/1ps
module vpa_plane_access
    import vpa_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Register port access from the host
    input  wire vpa_io_req_s           io_req,
    output logic                       io_claim,
    output logic [7:0]                 io_rdata,
    output logic                       io_rvalid,
    // Display memory access from the host
    input  wire vpa_mem_req_s          mem_req,
    output logic                       mem_rvalid,
    output logic [7:0]                 mem_rdata,
    // Settings from neighbouring graphics registers
    input  wire logic [1:0]            write_mode,
    input  wire logic                  read_mode,
    input  wire logic [3:0]            plane_compare_include,
    input  wire logic [7:0]            write_bit_mask,
    input  wire logic [7:0]            rotated_data,
    input  wire logic [1:0]            read_plane_sel,
    // Planar memory
    output vpa_plane_req_s             plane_req,
    input  wire vpa_plane_bytes_t      plane_rdata,
    // Text font path
    input  wire logic                  attr_bit3,
    output logic                       attr_selects_font,
    output logic [2:0]                 font_map_num,
    output logic [VPA_PLANE_AW-1:0]    font_base,
    output logic                       intensity,
    // Display timing
    input  wire logic                  hdisp_en,
    output logic                       hcount_held,
    output logic                       line_clk_en
);

    // Stored registers, reserved bits never stored
    logic [VPA_SEQ_IDX_W-1:0] seq_index;
    logic [VPA_GFX_IDX_W-1:0] gfx_index;
    logic [3:0]               plane_write_mask;
    logic [VPA_FONT_W-1:0]    font_bank_select;
    logic [7:0]               memory_map_mode;
    logic [7:0]               hcount_hold_reset;
    logic [3:0]               plane_fill_value;
    logic [3:0]               plane_fill_enable;
    logic [3:0]               plane_match_color;
    logic                     hold;

    // Replicate a plane bit across a byte
    function automatic logic [7:0] fill_byte(input logic b);
        fill_byte = {8{b}};
    endfunction : fill_byte

    // Bank code {hi pair, lo bit}; without extended memory only maps 0 and 4
    function automatic logic [2:0] bank_code(input logic [1:0] pair, input logic top,
                                             input logic ext);
        bank_code = ext ? {pair, top} : {2'h0, top};
    endfunction : bank_code

    // Map number is the pair plus four times the top bit
    function automatic logic [2:0] map_of(input logic [2:0] code);
        map_of = {code[0], code[2:1]};
    endfunction : map_of

    // Port decode
    wire hit_seq_idx = io_req.addr == VPA_SEQ_INDEX_PORT;
    wire hit_seq_dat = io_req.addr == VPA_SEQ_DATA_PORT;
    wire hit_gfx_idx = io_req.addr == VPA_GFX_INDEX_PORT;
    wire hit_gfx_dat = io_req.addr == VPA_GFX_DATA_PORT;

    assign io_claim  = (io_req.wr | io_req.rd) & (hit_seq_idx | hit_seq_dat |
                                                  hit_gfx_idx | hit_gfx_dat);

    // Data port writes land on the register the index names
    wire seq_wr      = io_req.wr & hit_seq_dat;
    wire gfx_wr      = io_req.wr & hit_gfx_dat;
    wire wr_pmask    = seq_wr & (seq_index == VPA_SEQ_PLANE_MASK);
    wire wr_font     = seq_wr & (seq_index == VPA_SEQ_FONT_SEL);
    wire wr_mmode    = seq_wr & (seq_index == VPA_SEQ_MEM_MODE);
    wire wr_hhold    = seq_wr & (seq_index == VPA_SEQ_HC_HOLD);
    wire wr_fill_val = gfx_wr & (gfx_index == VPA_GFX_FILL_VAL);
    wire wr_fill_en  = gfx_wr & (gfx_index == VPA_GFX_FILL_EN);
    wire wr_match    = gfx_wr & (gfx_index == VPA_GFX_MATCH_COL);

    // Index ports and sequencer registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            seq_index         <= '0;
            gfx_index         <= '0;
            plane_write_mask  <= VPA_RST_PLANE;
            font_bank_select  <= '0;
            memory_map_mode   <= VPA_RST_BYTE;
            hcount_hold_reset <= VPA_RST_BYTE;
        end
        else
        begin
            if (io_req.wr & hit_seq_idx)
                seq_index <= io_req.wdata[VPA_SEQ_IDX_W-1:0];
            if (io_req.wr & hit_gfx_idx)
                gfx_index <= io_req.wdata[VPA_GFX_IDX_W-1:0];
            if (wr_pmask)
                plane_write_mask <= io_req.wdata[3:0];
            if (wr_font)
                font_bank_select <= io_req.wdata[VPA_FONT_W-1:0];
            if (wr_mmode)
                memory_map_mode <= io_req.wdata & VPA_MM_DEFINED;
            if (wr_hhold)
                hcount_hold_reset <= io_req.wdata;
        end
    end

    // Graphics fill and compare registers; undefined at reset, cleared here
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            plane_fill_value  <= VPA_RST_PLANE;
            plane_fill_enable <= VPA_RST_PLANE;
            plane_match_color <= VPA_RST_PLANE;
        end
        else
        begin
            if (wr_fill_val)
                plane_fill_value <= io_req.wdata[3:0];
            if (wr_fill_en)
                plane_fill_enable <= io_req.wdata[3:0];
            if (wr_match)
                plane_match_color <= io_req.wdata[3:0];
        end
    end

    // Counter hold: any write at index 7 sets, index 0-6 releases
    wire next_hold = wr_hhold ? 1'b1 : (seq_wr ? 1'b0 : hold);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hold <= 1'b0;
        else
            hold <= next_hold;
    end
    assign hcount_held = hold;

    // A held horizontal counter gives no display enable, so lines stop too
    assign line_clk_en = hdisp_en & ~hold;

    // Register readback; unmapped graphics indices read zero here
    logic [7:0] seq_rd_mux;
    logic [7:0] gfx_rd_mux;

    always_comb
    begin
        seq_rd_mux = 8'h00;
        unique case (seq_index)
            VPA_SEQ_PLANE_MASK: seq_rd_mux = {4'h0, plane_write_mask};
            VPA_SEQ_FONT_SEL:   seq_rd_mux = {2'h0, font_bank_select};
            VPA_SEQ_MEM_MODE:   seq_rd_mux = memory_map_mode;
            VPA_SEQ_HC_HOLD:    seq_rd_mux = hcount_hold_reset;
            default:            seq_rd_mux = 8'h00;
        endcase
    end

    always_comb
    begin
        gfx_rd_mux = 8'h00;
        unique case (gfx_index)
            VPA_GFX_FILL_VAL:  gfx_rd_mux = {4'h0, plane_fill_value};
            VPA_GFX_FILL_EN:   gfx_rd_mux = {4'h0, plane_fill_enable};
            VPA_GFX_MATCH_COL: gfx_rd_mux = {4'h0, plane_match_color};
            default:           gfx_rd_mux = 8'h00;
        endcase
    end

    wire [7:0] next_io_rdata = hit_seq_idx ? {5'h00, seq_index} :
                               hit_seq_dat ? seq_rd_mux :
                               hit_gfx_idx ? {4'h0, gfx_index} :
                               hit_gfx_dat ? gfx_rd_mux : 8'h00;

    // Read data is registered; one cycle after the read strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end
        else
        begin
            io_rvalid <= io_req.rd;
            io_rdata  <= io_req.rd ? next_io_rdata : 8'h00;
        end
    end

    // Font bank selection into plane 2
    wire       ext_mem = memory_map_mode[VPA_MM_EXT];
    wire [2:0] code_a  = bank_code(font_bank_select[1:0], font_bank_select[VPA_FONT_A_HI],
                                   ext_mem);
    wire [2:0] code_b  = bank_code(font_bank_select[3:2], font_bank_select[VPA_FONT_B_HI],
                                   ext_mem);

    wire       fonts_differ = code_a != code_b;
    wire       use_b        = fonts_differ & attr_bit3;
    wire [2:0] code_sel     = use_b ? code_b : code_a;

    wire [VPA_PLANE_AW-1:0] next_font_base = {code_sel, {VPA_BANK_SHIFT{1'b0}}};

    // Font outputs are registered, one cycle behind the attribute
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            attr_selects_font <= 1'b0;
            font_map_num      <= 3'h0;
            font_base         <= '0;
            intensity         <= 1'b0;
        end
        else
        begin
            attr_selects_font <= fonts_differ;
            font_map_num      <= map_of(code_sel);
            font_base         <= next_font_base;
            intensity         <= ~fonts_differ & attr_bit3;
        end
    end

    // Address steering for display memory
    logic [VPA_PLANES-1:0]   steer_en;
    logic [1:0]              steer_rplane;
    logic [VPA_PLANE_AW-1:0] steer_off;
    logic                    steer_ok;

    vpa_plane_steer u_steer (
        .chain4         (memory_map_mode[VPA_MM_CHAIN4]),
        .seq_addr       (memory_map_mode[VPA_MM_SEQ]),
        .ext_mem        (ext_mem),
        .cpu_addr       (mem_req.addr),
        .is_write       (mem_req.wr),
        .write_mask     (plane_write_mask),
        .read_plane_sel (read_plane_sel),
        .plane_en       (steer_en),
        .read_plane     (steer_rplane),
        .plane_off      (steer_off),
        .in_range       (steer_ok)
    );

    // Per-plane write data and bit mask from the write mode
    vpa_plane_bytes_t next_wdata;
    logic [7:0]       next_bitmask;
    wire              wm0 = write_mode == VPA_WMODE_0;
    wire              wm3 = write_mode == VPA_WMODE_3;

    always_comb
    begin
        next_wdata = '0;
        for (int p = 0; p < VPA_PLANES; p++)
        begin
            if ((wm0 & plane_fill_enable[p]) | wm3)
                next_wdata[p] = fill_byte(plane_fill_value[p]);
            else
                next_wdata[p] = rotated_data;
        end
    end

    // Mode 3 narrows the bit mask with the rotated data
    assign next_bitmask = wm3 ? (rotated_data & write_bit_mask) : write_bit_mask;

    wire mem_wr_ok = mem_req.wr & steer_ok;
    wire mem_rd_ok = mem_req.rd & steer_ok;

    // Plane request issued the cycle after the host access
    logic       rd_pend;
    logic       rd_out_of_range;
    logic [1:0] rd_plane;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            plane_req       <= '0;
            rd_pend         <= 1'b0;
            rd_out_of_range <= 1'b0;
            rd_plane        <= 2'h0;
        end
        else
        begin
            plane_req.we      <= mem_wr_ok ? steer_en : VPA_RST_PLANE;
            plane_req.we_any  <= mem_wr_ok & (steer_en != VPA_RST_PLANE);
            plane_req.re      <= mem_rd_ok;
            plane_req.addr    <= steer_off;
            plane_req.data    <= next_wdata;
            plane_req.bitmask <= next_bitmask;
            rd_pend           <= mem_req.rd;
            rd_out_of_range   <= mem_req.rd & ~steer_ok;
            rd_plane          <= steer_rplane;
        end
    end

    // Colour compare across included planes, one result bit per byte bit
    logic [7:0] cmp_bits;

    always_comb
    begin
        cmp_bits = 8'hff;
        for (int p = 0; p < VPA_PLANES; p++)
        begin
            if (plane_compare_include[p])
                cmp_bits = cmp_bits & ~(plane_rdata[p] ^ fill_byte(plane_match_color[p]));
        end
    end

    // Plane data returns one cycle after the plane read; register the answer
    logic       rd_pend_d;
    logic       rd_oor_d;
    logic [1:0] rd_plane_d;

    wire  [7:0] next_mem_rdata = rd_oor_d ? 8'h00 :
                                 read_mode ? cmp_bits : plane_rdata[rd_plane_d];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_pend_d  <= 1'b0;
            rd_oor_d   <= 1'b0;
            rd_plane_d <= 2'h0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 8'h00;
        end
        else
        begin
            rd_pend_d  <= rd_pend;
            rd_oor_d   <= rd_out_of_range;
            rd_plane_d <= rd_plane;
            mem_rvalid <= rd_pend_d;
            mem_rdata  <= rd_pend_d ? next_mem_rdata : 8'h00;
        end
    end

endmodule : vpa_plane_access

// ==== tb/vpa_plane_access_props.sv ====
`timescale 1ns/1ps
module vpa_plane_access_props
    import vpa_pkg::*;
(
    // Clock and reset
    input wire logic           clk,
    input wire logic           rst,
    // Host side
    input wire vpa_io_req_s    io_req,
    input wire logic           io_claim,
    input wire logic           io_rvalid,
    input wire vpa_mem_req_s   mem_req,
    input wire logic           mem_rvalid,
    // Plane and timing side
    input wire vpa_plane_req_s plane_req,
    input wire logic           hdisp_en,
    input wire logic           hcount_held,
    input wire logic           line_clk_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Shadows of the index, plane mask and extended memory bit
    logic [2:0] sh_idx;
    logic [3:0] sh_mask;
    logic       sh_ext;
    wire        seq_dwr  = io_req.wr && io_req.addr == VPA_SEQ_DATA_PORT;
    wire        port_hit = io_req.addr inside {VPA_SEQ_INDEX_PORT, VPA_SEQ_DATA_PORT,
                                               VPA_GFX_INDEX_PORT, VPA_GFX_DATA_PORT};

    // Updated on the same edge as the block's registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sh_idx  <= 3'h0;
            sh_mask <= 4'h0;
            sh_ext  <= 1'b0;
        end
        else
        begin
            if (io_req.wr && io_req.addr == VPA_SEQ_INDEX_PORT)
                sh_idx <= io_req.wdata[2:0];
            if (seq_dwr && sh_idx == VPA_SEQ_PLANE_MASK)
                sh_mask <= io_req.wdata[3:0];
            if (seq_dwr && sh_idx == VPA_SEQ_MEM_MODE)
                sh_ext <= io_req.wdata[VPA_MM_EXT];
        end
    end

    rd_answer_a: assert property (io_req.rd |=> io_rvalid)
        else $error("read unanswered");
    rvalid_cause_a: assert property (io_rvalid |-> $past(io_req.rd))
        else $error("answer without read");
    port_claim_a: assert property (io_claim == ((io_req.wr || io_req.rd) && port_hit))
        else $error("port claim wrong");
    hold_set_a: assert property (seq_dwr && sh_idx == 3'h7 |=> hcount_held)
        else $error("counter hold not set");
    hold_clear_a: assert property (seq_dwr && sh_idx != 3'h7 |=> !hcount_held)
        else $error("counter hold not released");
    line_gate_a: assert property (line_clk_en == (hdisp_en && !hcount_held))
        else $error("line clock enable wrong");
    mem_lat_a: assert property (mem_req.rd |-> ##3 mem_rvalid)
        else $error("memory read answer late");
    range_block_a: assert property (mem_req.wr && !sh_ext && mem_req.addr[17:16] != 2'h0
        |=> plane_req.we == 4'h0)
        else $error("write beyond 64 KB");
    read_issue_a: assert property (mem_req.rd && (sh_ext || mem_req.addr[17:16] == 2'h0)
        |=> plane_req.re)
        else $error("plane read not issued");
    mask_gate_a: assert property (mem_req.wr |=> (plane_req.we & ~$past(sh_mask)) == 4'h0)
        else $error("masked plane written");
endmodule : vpa_plane_access_props

// ==== tb/vpa_host_model.sv ====
`timescale 1ns/1ps
module vpa_host_model
    import vpa_pkg::*;
(
    // Clock
    input wire logic           clk,
    // Requests
    output vpa_io_req_s        io_req,
    output vpa_mem_req_s       mem_req,
    // Answers
    input wire logic           io_rvalid,
    input wire logic [7:0]     io_rdata,
    input wire logic           mem_rvalid,
    input wire logic [7:0]     mem_rdata,
    input wire vpa_plane_req_s plane_req
);
    initial
    begin
        io_req  = '0;
        mem_req = '0;
    end

    // Call just after an edge; released lines show their inverse, then an edge passes
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        io_req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #2 io_req = '{1'b0, 1'b0, ~a, ~d};
        @(posedge clk) #2;
    endtask : io_wr

    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        io_req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #2 io_req = '{1'b0, 1'b0, ~a, 8'hff};
        d = io_rvalid ? io_rdata : 8'hxx;
        @(posedge clk) #2;
    endtask : io_rd

    // Index first, then data port; the index persists between calls
    task automatic reg_wr(input logic gfx, input logic [3:0] i, input logic [7:0] d);
        io_wr(gfx ? VPA_GFX_INDEX_PORT : VPA_SEQ_INDEX_PORT, {4'h0, i});
        io_wr(gfx ? VPA_GFX_DATA_PORT : VPA_SEQ_DATA_PORT, d);
    endtask : reg_wr

    task automatic reg_rd(input logic gfx, input logic [3:0] i, output logic [7:0] d);
        io_wr(gfx ? VPA_GFX_INDEX_PORT : VPA_SEQ_INDEX_PORT, {4'h0, i});
        io_rd(gfx ? VPA_GFX_DATA_PORT : VPA_SEQ_DATA_PORT, d);
    endtask : reg_rd

    task automatic mem_wr(input logic [17:0] a, output vpa_plane_req_s p);
        mem_req = '{1'b1, 1'b0, a};
        @(posedge clk);
        #2 mem_req = '{1'b0, 1'b0, ~a};
        p = plane_req;
        @(posedge clk) #2;
    endtask : mem_wr

    task automatic mem_rd(input logic [17:0] a, output logic [7:0] d);
        mem_req = '{1'b0, 1'b1, a};
        @(posedge clk);
        #2 mem_req = '{1'b0, 1'b0, ~a};
        for (int n = 0; n < 6 && !mem_rvalid; n++)
            @(posedge clk) #2;
        d = mem_rvalid ? mem_rdata : 8'hxx;
    endtask : mem_rd
endmodule : vpa_host_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import vpa_pkg::*;
;
    logic clk, rst, io_claim, io_rvalid, mem_rvalid, read_mode, attr_bit3, hdisp_en;
    logic attr_selects_font, intensity, hcount_held, line_clk_en, re_d;
    logic [1:0] write_mode, read_plane_sel;
    logic [3:0] plane_compare_include;
    logic [7:0] io_rdata, mem_rdata, write_bit_mask, rotated_data, d;
    logic [2:0] font_map_num;
    logic [15:0] font_base;
    vpa_io_req_s io_req;
    vpa_mem_req_s mem_req;
    vpa_plane_req_s plane_req, p;
    vpa_plane_bytes_t plane_rdata, pat;
    int err_total = 0;
    int check_count = 0;

    vpa_plane_access dut (.clk, .rst, .io_req, .io_claim, .io_rdata, .io_rvalid, .mem_req,
        .mem_rvalid, .mem_rdata, .write_mode, .read_mode, .plane_compare_include,
        .write_bit_mask, .rotated_data, .read_plane_sel, .plane_req, .plane_rdata, .attr_bit3,
        .attr_selects_font, .font_map_num, .font_base, .intensity, .hdisp_en, .hcount_held,
        .line_clk_en);

    vpa_host_model host (.clk, .io_req, .mem_req, .io_rvalid, .io_rdata, .mem_rvalid,
        .mem_rdata, .plane_req);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Planes answer the cycle after a read strobe
    always @(posedge clk)
    begin
        re_d <= plane_req.re;
        #2 plane_rdata = re_d ? pat : ~pat;
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task automatic font_chk(input logic [7:0] fb, input logic a3, input logic [4:0] exp);
        host.reg_wr(1'b0, 4'h3, fb);
        attr_bit3 = a3;
        repeat (2) @(posedge clk);
        #2 chk("font", {attr_selects_font, intensity, font_map_num}, exp);
    endtask : font_chk

    // Register table: gfx, index, written, read back
    logic [20:0] rt [10] = '{21'h02ff0f, 21'h03ff3f, 21'h04ff0e, 21'h07a5a5, 21'h00ff00,
        21'h05ff00, 21'h10ff0f, 21'h11ff0f, 21'h12ff0f, 21'h13ff00};
    // Writes: mode, mask, address, enables
    logic [35:0] wt [7] = '{36'h0eb000020, 36'h0eb000038, 36'h02f00001a, 36'h02f000005,
        36'h066000056, 36'h00f100000, 36'h02f100005};
    // Reads: mode, read mode, include, address, byte
    logic [43:0] rdt [5] = '{44'h06000000033, 44'h0e000000130, 44'h061300000c0,
        44'h061000000ff, 44'h00001000000};
    logic [1:0] wm [3] = '{2'h0, 2'h3, 2'h1};
    logic [39:0] wd [3] = '{40'h3c003cfff0, 40'h000000ff30, 40'h3c3c3c3cf0};

    initial
    begin
        #100000;
        err_total++;
        end_sim();
    end

    initial
    begin
        rst = 1'b1;
        {write_mode, read_mode, plane_compare_include, write_bit_mask} = '0;
        {rotated_data, read_plane_sel, attr_bit3, hdisp_en} = '0;
        pat = 32'h443330f0;
        repeat (3) @(posedge clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            host.reg_rd(rt[i][20], rt[i][19:16], d);
            chk("reset", d, 8'h00);
            host.reg_wr(rt[i][20], rt[i][19:16], rt[i][15:8]);
            host.reg_rd(rt[i][20], rt[i][19:16], d);
            chk("readback", d, rt[i][7:0]);
        end
        host.io_wr(VPA_SEQ_INDEX_PORT, 8'hff);
        host.io_rd(VPA_SEQ_INDEX_PORT, d);
        chk("seq index", d, 8'h07);
        host.io_wr(VPA_GFX_INDEX_PORT, 8'hff);
        host.io_rd(VPA_GFX_INDEX_PORT, d);
        chk("gfx index", d, 8'h0f);
        // Counter hold: an index write alone must not release it
        hdisp_en = 1'b1;
        host.reg_wr(1'b0, 4'h7, 8'h00);
        chk("held", {hcount_held, line_clk_en}, 2'b10);
        host.io_wr(VPA_SEQ_INDEX_PORT, 8'h06);
        chk("held idx", hcount_held, 1'b1);
        host.io_wr(VPA_SEQ_DATA_PORT, 8'h00);
        chk("released", {hcount_held, line_clk_en}, 2'b01);
        for (int i = 0; i < 7; i++)
        begin
            host.reg_wr(1'b0, 4'h2, {4'h0, wt[i][27:24]});
            host.reg_wr(1'b0, 4'h4, wt[i][35:28]);
            host.mem_wr(wt[i][21:4], p);
            chk("plane we", p.we, wt[i][3:0]);
        end
        host.reg_wr(1'b0, 4'h4, 8'h06);
        host.reg_wr(1'b1, 4'h0, 8'h01);
        host.reg_wr(1'b1, 4'h1, 8'h05);
        rotated_data = 8'h3c;
        write_bit_mask = 8'hf0;
        for (int i = 0; i < 3; i++)
        begin
            write_mode = wm[i];
            host.mem_wr(18'h4, p);
            chk("plane data", {p.data, p.bitmask}, wd[i]);
            chk("plane addr", {p.we_any, p.addr}, 17'h10004);
        end
        host.reg_wr(1'b1, 4'h2, 8'h05);
        read_plane_sel = 2'h2;
        for (int i = 0; i < 5; i++)
        begin
            host.reg_wr(1'b0, 4'h4, rdt[i][43:36]);
            read_mode = rdt[i][32];
            plane_compare_include = rdt[i][31:28];
            host.mem_rd(rdt[i][25:8], d);
            chk("read", d, rdt[i][7:0]);
        end
        // Font: {selects font, intensity, map number}
        host.reg_wr(1'b0, 4'h4, 8'h02);
        font_chk(8'h01, 1'b0, 5'b10001);
        font_chk(8'h24, 1'b1, 5'b10101);
        host.reg_wr(1'b0, 4'h4, 8'h00);
        font_chk(8'h24, 1'b1, 5'b10100);
        font_chk(8'h00, 1'b1, 5'b01000);
        chk("font base", font_base, 16'h0000);
        end_sim();
    end
endmodule : tb_top

bind vpa_plane_access vpa_plane_access_props u_props (.clk, .rst, .io_req, .io_claim,
    .io_rvalid, .mem_req, .mem_rvalid, .plane_req, .hdisp_en, .hcount_held, .line_clk_en);
